//--- rtl/stom_pkg.sv
// Package of constants and types for the safe torque off monitor.
// Contract
// RL1: Auto-clear setting one clears when channels return.
// RL2: Single-channel or circuit fault needs manual reset.
// RL3: Read-only card-present flag, zero by default.
// RL4: Status: ones digit A, tens digit B.
// RL5: Prompt setting picks warning or fault class.
// RL6: Both channels lost enters torque-off state.
// RL7: Start commands ignored while torque is off.
// RL8: Running motor loses drive on torque off.
// RL9: After clearing, start is accepted again.
// RL10: Any channel low blocks all switching pulses.
// RL11: Single channel loss latches its own fault.
// RL12: Channel inputs pass two synchroniser flip-flops.
package stom_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the APB bus.
  // ----------------------------------------------------------------
  localparam logic [7:0] STOM_CTRL_ADDR = 8'h00;
  localparam logic [7:0] STOM_CMD_ADDR = 8'h04;
  localparam logic [7:0] STOM_STAT_ADDR = 8'h08;
  localparam logic [7:0] STOM_CHAN_ADDR = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int STOM_CTRL_AUTO_BIT = 0; // Auto-clear enable.
  localparam int STOM_CTRL_PROMPT_BIT = 1; // Fault prompt select.
  localparam int STOM_CMD_RESET_BIT = 0; // Manual reset, self-clearing.
  localparam int STOM_CMD_START_BIT = 1; // Start command.
  localparam int STOM_CMD_STOP_BIT = 2; // Stop command.
  localparam int STOM_CHAN_ONES_BIT = 0; // Channel A abnormal digit.
  localparam int STOM_CHAN_TENS_BIT = 4; // Channel B abnormal digit.

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic STOM_AUTO_RST = 1'h1;
  localparam logic STOM_PROMPT_RST = 1'h0;
  localparam logic [31:0] STOM_ZERO_WORD = 32'h0000_0000;

  // Drive run control states, Gray coded along stop, run, block.
  typedef enum logic [1:0]
  {
    STOM_STOPPED = 2'h0,
    STOM_RUNNING = 2'h1,
    STOM_BLOCKED = 2'h3
  } stom_run_t;

  // Status word as software reads it, high bit first.
  typedef struct packed
  {
    logic card_present;  // Bit 6: option card detected.
    logic circuit_fault; // Bit 5: internal circuit fault latched.
    logic fault;         // Bit 4: a fault class indication is up.
    logic warning;       // Bit 3: a warning class indication is up.
    logic running;       // Bit 2: motor is being driven.
    logic pwm_enable;    // Bit 1: switching pulses permitted.
    logic torque_off;    // Bit 0: torque-off state active.
  } stom_status_t;

endpackage

//--- rtl/stom_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/100ps
module stom_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // First stage, read only by the second stage.
  logic [WIDTH-1:0] meta_ff;

  // ----------------------------------------------------------------
  // Synchroniser stages.
  // ----------------------------------------------------------------
  // Both stages reset low so that channels read as lost until sampled.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_ff <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_ff <= i_async; // RL12
      o_sync <= meta_ff; // RL12
    end
  end

endmodule

//--- rtl/stom_top.sv
// Safe torque off monitor with its APB register slave.
`timescale 1ns/100ps
module stom_top
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_safety_channel_a,
  input wire logic i_safety_channel_b,
  input wire logic i_circuit_fault,
  input wire logic i_card_detect,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_pwm_enable,
  output logic o_torque_off,
  output logic o_channel_a_fault_code,
  output logic o_channel_b_fault_code,
  output logic o_circuit_fault_code,
  output logic o_warning,
  output logic o_fault,
  output stom_pkg::stom_status_t o_status
);
  import stom_pkg::*;

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  logic [3:0] pins_sync; // Synchronised pin levels.
  logic chan_a_ok; // Channel A connected.
  logic chan_b_ok; // Channel B connected.
  logic circ_fault_in; // Internal circuit fault level.
  logic card_in; // Option card detect level.
  logic auto_clear_enable_ff; // Auto-clear enable setting.
  logic fault_prompt_select_ff; // Prompt class setting.
  logic manual_reset_ff; // One-cycle manual reset pulse.
  logic start_cmd_ff; // One-cycle start command pulse.
  logic stop_cmd_ff; // One-cycle stop command pulse.
  logic sto_abn_ff; // Torque-off abnormal latch.
  logic chan_a_fault_ff; // Channel A only loss latch.
  logic chan_b_fault_ff; // Channel B only loss latch.
  logic circ_fault_ff; // Internal circuit fault latch.
  logic [7:0] channel_fault_status_ff; // Two-digit channel status.
  stom_run_t run_ff; // Run control state.
  stom_run_t nxt_run; // Next run control state.
  logic block_all; // Any reason to withhold torque.
  logic setup_phase; // APB setup cycle.
  logic wr_access; // APB write taking effect.
  logic addr_hit; // Address is mapped.
  logic [31:0] nxt_prdata; // Read data for the current address.

  assign chan_a_ok = pins_sync[0];
  assign chan_b_ok = pins_sync[1];
  assign circ_fault_in = pins_sync[2];
  assign card_in = pins_sync[3];

  // ----------------------------------------------------------------
  // Input synchronisation.
  // ----------------------------------------------------------------
  // All pins cross into the clock domain before any logic reads them.
  stom_sync #(.WIDTH(4)) u_sync
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_card_detect, i_circuit_fault, i_safety_channel_b,
              i_safety_channel_a}),
    .o_sync(pins_sync)
  );

  // ----------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------
  // A write lands only at the access edge where ready is high.
  assign setup_phase = i_psel & ~i_penable;
  assign wr_access = i_psel & i_penable & o_pready & i_pwrite;

  // Unmapped addresses answer with an error and read as zero.
  always_comb
  begin
    addr_hit = 1'b1;
    nxt_prdata = STOM_ZERO_WORD;
    unique case (i_paddr)
      STOM_CTRL_ADDR:
      begin
        nxt_prdata[STOM_CTRL_AUTO_BIT] = auto_clear_enable_ff;
        nxt_prdata[STOM_CTRL_PROMPT_BIT] = fault_prompt_select_ff;
      end
      // Command bits read as zero.
      STOM_CMD_ADDR: nxt_prdata = STOM_ZERO_WORD;
      STOM_STAT_ADDR: nxt_prdata[$bits(stom_status_t)-1:0] = o_status;
      STOM_CHAN_ADDR: nxt_prdata[7:0] = channel_fault_status_ff; // RL4
      default: addr_hit = 1'b0;
    endcase
  end

  // The slave answers in the first access cycle, no wait states.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= STOM_ZERO_WORD;
    end
    else
    begin
      o_pready <= setup_phase;
      o_pslverr <= setup_phase & ~addr_hit;
      if (setup_phase & ~i_pwrite)
      begin
        o_prdata <= nxt_prdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration register.
  // ----------------------------------------------------------------
  // Settings steer clearing and the class of the indication.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      auto_clear_enable_ff <= STOM_AUTO_RST; // RL1
      fault_prompt_select_ff <= STOM_PROMPT_RST; // RL5
    end
    else if (wr_access && i_paddr == STOM_CTRL_ADDR)
    begin
      auto_clear_enable_ff <= i_pwdata[STOM_CTRL_AUTO_BIT];
      fault_prompt_select_ff <= i_pwdata[STOM_CTRL_PROMPT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Command pulses.
  // ----------------------------------------------------------------
  // A write to the command word yields one-cycle pulses.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      manual_reset_ff <= 1'b0;
      start_cmd_ff <= 1'b0;
      stop_cmd_ff <= 1'b0;
    end
    else
    begin
      manual_reset_ff <= wr_access && i_paddr == STOM_CMD_ADDR
                         && i_pwdata[STOM_CMD_RESET_BIT];
      start_cmd_ff <= wr_access && i_paddr == STOM_CMD_ADDR
                      && i_pwdata[STOM_CMD_START_BIT];
      stop_cmd_ff <= wr_access && i_paddr == STOM_CMD_ADDR
                     && i_pwdata[STOM_CMD_STOP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Abnormal state latches.
  // ----------------------------------------------------------------
  // Setting has priority, so a loss coinciding with a reset stays.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sto_abn_ff <= 1'b0;
      chan_a_fault_ff <= 1'b0;
      chan_b_fault_ff <= 1'b0;
      circ_fault_ff <= 1'b0;
    end
    else
    begin
      // Both channels lost: torque-off abnormal state.
      if (~chan_a_ok & ~chan_b_ok)
        sto_abn_ff <= 1'b1; // RL6
      else if (chan_a_ok & chan_b_ok
               & (auto_clear_enable_ff | manual_reset_ff))
        sto_abn_ff <= 1'b0; // RL1
      // A skewed return from both lost must not defeat auto-clear.
      if (~chan_a_ok & chan_b_ok & ~sto_abn_ff)
        chan_a_fault_ff <= 1'b1; // RL11
      else if (chan_a_ok & manual_reset_ff)
        chan_a_fault_ff <= 1'b0; // RL2
      if (chan_a_ok & ~chan_b_ok & ~sto_abn_ff)
        chan_b_fault_ff <= 1'b1; // RL11
      else if (chan_b_ok & manual_reset_ff)
        chan_b_fault_ff <= 1'b0; // RL2
      // Internal circuit fault, manual reset after it goes away.
      if (circ_fault_in)
        circ_fault_ff <= 1'b1; // RL2
      else if (manual_reset_ff)
        circ_fault_ff <= 1'b0; // RL2
    end
  end

  // Torque is withheld while a channel is low or anything is latched.
  assign block_all = ~chan_a_ok | ~chan_b_ok | sto_abn_ff
                     | chan_a_fault_ff | chan_b_fault_ff
                     | circ_fault_ff; // RL10

  // ----------------------------------------------------------------
  // Run control.
  // ----------------------------------------------------------------
  // Starts are refused while blocked; blocking drops a running motor.
  always_comb
  begin
    nxt_run = run_ff;
    unique case (run_ff)
      STOM_STOPPED:
      begin
        if (block_all)
          nxt_run = STOM_BLOCKED;
        else if (start_cmd_ff)
          nxt_run = STOM_RUNNING; // RL9
      end
      STOM_RUNNING:
      begin
        if (block_all)
          nxt_run = STOM_BLOCKED; // RL8
        else if (stop_cmd_ff)
          nxt_run = STOM_STOPPED;
      end
      STOM_BLOCKED:
      begin
        // Start pulses are dropped here, a fresh start is needed.
        if (~block_all)
          nxt_run = STOM_STOPPED; // RL7
      end
      default:
      begin
        nxt_run = STOM_BLOCKED;
      end
    endcase
  end

  // Run state register, blocked out of reset until channels are seen.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      run_ff <= STOM_BLOCKED;
    end
    else
    begin
      run_ff <= nxt_run;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and status.
  // ----------------------------------------------------------------
  // Pulses are enabled only when running and nothing blocks.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pwm_enable <= 1'b0;
      o_torque_off <= 1'b0;
      o_channel_a_fault_code <= 1'b0;
      o_channel_b_fault_code <= 1'b0;
      o_circuit_fault_code <= 1'b0;
      o_warning <= 1'b0;
      o_fault <= 1'b0;
      channel_fault_status_ff <= 8'h00;
      o_status <= '0;
    end
    else
    begin
      o_pwm_enable <= (nxt_run == STOM_RUNNING) & ~block_all; // RL10
      o_torque_off <= sto_abn_ff; // RL6
      o_channel_a_fault_code <= chan_a_fault_ff; // RL11
      o_channel_b_fault_code <= chan_b_fault_ff; // RL11
      o_circuit_fault_code <= circ_fault_ff;
      o_warning <= sto_abn_ff & ~fault_prompt_select_ff; // RL5
      o_fault <= (sto_abn_ff & fault_prompt_select_ff) | chan_a_fault_ff
                 | chan_b_fault_ff | circ_fault_ff; // RL5
      channel_fault_status_ff <= 8'h00;
      channel_fault_status_ff[STOM_CHAN_ONES_BIT] <=
        ~chan_a_ok | chan_a_fault_ff; // RL4
      channel_fault_status_ff[STOM_CHAN_TENS_BIT] <=
        ~chan_b_ok | chan_b_fault_ff; // RL4
      o_status.card_present <= card_in; // RL3
      o_status.circuit_fault <= circ_fault_ff;
      o_status.fault <= o_fault;
      o_status.warning <= o_warning;
      o_status.running <= run_ff == STOM_RUNNING;
      o_status.pwm_enable <= o_pwm_enable;
      o_status.torque_off <= o_torque_off;
    end
  end

endmodule

//--- verification/stom_monitor.sv
// Port checker for the safe torque off monitor.
`timescale 1ns/100ps
module stom_monitor
  import stom_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_safety_channel_a,
  input wire logic i_safety_channel_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_pwm_enable,
  input wire logic o_torque_off,
  input wire logic o_channel_a_fault_code,
  input wire logic o_circuit_fault_code,
  input wire logic o_warning,
  input wire logic o_fault,
  input stom_status_t o_status
);
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  // High in the access cycle of a manual reset write.
  logic clr_wr;
  assign clr_wr = i_psel & i_penable & i_pwrite
    & (i_paddr == STOM_CMD_ADDR) & i_pwdata[STOM_CMD_RESET_BIT];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Both contacts closed, then both opened together.
  sequence both_up;
    (i_safety_channel_a && i_safety_channel_b) [*3];
  endsequence
  sequence both_down;
    (!i_safety_channel_a && !i_safety_channel_b) [*5];
  endsequence
  // No manual reset write in the last three cycles.
  sequence no_clear;
    !clr_wr && !$past(clr_wr) && !$past(clr_wr, 2);
  endsequence

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  chk_pwm_block: assert property (
    (!i_safety_channel_a || !i_safety_channel_b) [*5] |-> !o_pwm_enable)
    else $error("Pulses permitted with a channel low.");
  chk_torque_set: assert property (
    both_up ##1 both_down |-> o_torque_off)
    else $error("Torque-off not entered.");
  chk_start_block: assert property (
    o_torque_off [*3] |-> !o_status.running)
    else $error("Motor driven during torque-off.");
  chk_class_shown: assert property (
    o_torque_off [*3] |-> o_warning || o_fault)
    else $error("Torque-off without class flag.");
  chk_a_hold: assert property (
    o_channel_a_fault_code ##0 no_clear |=> o_channel_a_fault_code)
    else $error("Channel A latch cleared alone.");
  chk_circ_hold: assert property (
    o_circuit_fault_code ##0 no_clear |=> o_circuit_fault_code)
    else $error("Circuit latch cleared alone.");
  chk_sync_delay: assert property (
    $fell(i_safety_channel_a) && i_safety_channel_b
    && $past(i_safety_channel_b) && o_pwm_enable |=> o_pwm_enable [*2])
    else $error("Channel seen before two sync stages.");
  chk_ready_time: assert property (
    i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("Ready not a single access-cycle pulse.");
  chk_err_pair: assert property (
    o_pslverr |-> o_pready)
    else $error("Error without ready.");
endmodule

bind stom_top stom_monitor i_stom_monitor (.i_clk, .i_rst,
  .i_safety_channel_a, .i_safety_channel_b, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_pwm_enable,
  .o_torque_off, .o_channel_a_fault_code, .o_circuit_fault_code,
  .o_warning, .o_fault, .o_status);

//--- verification/stom_switch.sv
// Model of the external two-contact safety switch.
`timescale 1ns/100ps
module stom_switch
#(
  parameter int LAG = 6
)
(
  input wire logic i_clk,
  input wire logic i_open_a,
  input wire logic i_open_b,
  input wire logic i_slow,
  output logic o_channel_a,
  output logic o_channel_b
);
  int lag; // Cycles a pending contact move has waited.
  logic pend; // A contact differs from its command.
  assign pend = (o_channel_a == i_open_a) || (o_channel_b == i_open_b);

  // Contacts start closed, so the drive powers up connected.
  initial
  begin
    o_channel_a = 1'b1;
    o_channel_b = 1'b1;
    lag = 0;
  end

  // A slow switch moves both contacts only after LAG cycles.
  always @(posedge i_clk)
  begin
    if (pend && (!i_slow || lag >= LAG))
    begin
      o_channel_a <= !i_open_a;
      o_channel_b <= !i_open_b;
      lag <= 0;
    end
    else if (pend)
      lag <= lag + 1;
  end
endmodule

//--- verification/stom_top_tb.sv
// Self-checking testbench of the safe torque off monitor.
`timescale 1ns/100ps
module stom_top_tb;
  import stom_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic i_safety_channel_a, i_safety_channel_b, o_pready, o_pslverr, err;
  logic o_pwm_enable, o_torque_off, o_channel_a_fault_code, o_warning;
  logic o_channel_b_fault_code, o_circuit_fault_code, o_fault;
  logic open_a = 1'b0, open_b = 1'b0, slow = 1'b0;
  logic i_circuit_fault = 1'b0, i_card_detect = 1'b0;
  stom_status_t o_status;
  int bad_count = 0;
  int tests_run = 0;

  always #2.5 i_clk = ~i_clk;

  stom_top i_stom_top (.i_clk, .i_rst, .i_safety_channel_a,
    .i_safety_channel_b, .i_circuit_fault, .i_card_detect, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .o_pwm_enable, .o_torque_off, .o_channel_a_fault_code,
    .o_channel_b_fault_code, .o_circuit_fault_code, .o_warning, .o_fault,
    .o_status);
  stom_switch i_stom_switch (.i_clk, .i_open_a(open_a), .i_open_b(open_b),
    .i_slow(slow), .o_channel_a(i_safety_channel_a),
    .o_channel_b(i_safety_channel_b));

  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic close_out;
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Bounded wait for a level; a timeout ends the run.
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 40)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(s === v, "wait timed out");
    if (s !== v)
      close_out();
  endtask

  // One APB transfer; read data and error land in rd and err.
  task automatic apb(input logic wr, input logic [7:0] ad,
    input logic [31:0] wd);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= ad;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    wait_for(o_pready, 1'b1);
    @(posedge i_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic start(input logic run);
    apb(1'b1, STOM_CMD_ADDR, 32'h0000_0002);
    idle(6);
    chk(o_status.running === run && o_pwm_enable === run, "start");
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_defaults;
    apb(1'b0, STOM_CTRL_ADDR, 32'h0);
    chk(rd === 32'h0000_0001, "control reset value");
    apb(1'b0, STOM_CHAN_ADDR, 32'h0);
    chk(rd === 32'h0, "channel status reset value");
    chk(o_status.card_present === 1'b0, "card flag default");
    i_card_detect <= 1'b1;
    apb(1'b1, STOM_STAT_ADDR, 32'h0);
    idle(4);
    apb(1'b0, STOM_STAT_ADDR, 32'h0);
    chk(rd[6] === 1'b1, "card flag read-only and set");
    apb(1'b0, 8'h10, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped access");
  endtask

  // Both contacts open; auto or manual clearing as chosen.
  task automatic t_both(input logic auto_on);
    apb(1'b1, STOM_CTRL_ADDR, auto_on ? 32'h1 : 32'h2);
    slow <= !auto_on;
    start(1'b1);
    open_a <= 1'b1;
    open_b <= 1'b1;
    wait_for(o_torque_off, 1'b1);
    idle(2);
    chk(o_pwm_enable === 1'b0, "pulses still allowed");
    chk(o_warning === auto_on && o_fault === !auto_on, "class");
    chk(o_status.running === 1'b0, "motor still driven");
    apb(1'b0, STOM_CHAN_ADDR, 32'h0);
    chk(rd === 32'h0000_0011, "both digits");
    apb(1'b0, STOM_STAT_ADDR, 32'h0);
    chk(rd === (auto_on ? 32'h49 : 32'h51), "status word");
    start(1'b0);
    open_a <= 1'b0;
    open_b <= 1'b0;
    if (!auto_on)
    begin
      idle(14);
      chk(o_torque_off === 1'b1, "cleared without reset");
      apb(1'b1, STOM_CMD_ADDR, 32'h0000_0001);
    end
    wait_for(o_torque_off, 1'b0);
    start(1'b1);
  endtask

  // One contact opens alone; its latch waits for manual reset.
  task automatic t_single(input logic on_a);
    open_a <= on_a;
    open_b <= !on_a;
    wait_for(o_pwm_enable, 1'b0);
    idle(3);
    chk((on_a ? o_channel_a_fault_code : o_channel_b_fault_code) === 1'b1
      && o_status.running === 1'b0, "single latch");
    apb(1'b0, STOM_CHAN_ADDR, 32'h0);
    chk(rd === (on_a ? 32'h1 : 32'h10), "one digit");
    open_a <= 1'b0;
    open_b <= 1'b0;
    idle(14);
    chk((on_a ? o_channel_a_fault_code : o_channel_b_fault_code) === 1'b1,
      "latch cleared alone");
    start(1'b0);
    apb(1'b1, STOM_CMD_ADDR, 32'h0000_0001);
    idle(4);
    chk(o_channel_a_fault_code === 1'b0 && o_channel_b_fault_code === 1'b0,
      "latch kept after reset");
    start(1'b1);
  endtask

  task automatic t_circuit;
    apb(1'b1, STOM_CMD_ADDR, 32'h0000_0004);
    idle(4);
    chk(o_status.running === 1'b0 && o_pwm_enable === 1'b0, "stop ignored");
    i_circuit_fault <= 1'b1;
    wait_for(o_circuit_fault_code, 1'b1);
    idle(1);
    i_circuit_fault <= 1'b0;
    idle(14);
    chk(o_circuit_fault_code === 1'b1, "circuit latch dropped");
    apb(1'b1, STOM_CMD_ADDR, 32'h0000_0001);
    idle(4);
    chk(o_circuit_fault_code === 1'b0, "circuit latch kept");
  endtask

  initial
  begin
    idle(6);
    i_rst <= 1'b0;
    idle(8);
    t_defaults();
    t_both(1'b0);
    t_both(1'b1);
    t_single(1'b1);
    t_single(1'b0);
    t_circuit();
    close_out();
  end
endmodule
